// >>> hw/sec_pkg.sv
// How it works
// - Memory write and status store run only if clock pulses are a multiple of eight.
// - Data-changing instructions need the enable latch set beforehand by set_enable_cmd.
// - Chip select must rise after the last bit's clock edge, before the next.
// - Last qualifying bit is opcode bit eight or a data byte's eighth bit.
// - Guard bits protect none, 0600h-07FFh, 0400h-07FFh or all; protected writes rejected.
// - Commands are whole bytes, most significant bit first, opcode byte first.
// - An undefined opcode makes the device ignore input until chip select rises.
// - Decode the six standard opcodes for enable, status and memory access.
// - Identification variant shares two opcodes, told apart by the following address; the code reads the address, then ignores both.
// - Memory commands carry two address bytes; only bits A10 to A0 count.
// - Only set_enable_cmd sets the latch; afterwards wait for deselect.
// - clear_enable_cmd clears the latch; afterwards wait for deselect.
// - Latch clears at power-up, clear command, and status store or write completion.
// - Status is readable anytime, repeated while clocking continues with select low.
// - busy_flag reads 1 during a write or status store cycle, else 0.
// - Latch reads 1 when set; at 0 all writes and status stores are refused.
// - Guard bits are non-volatile and change only by an allowed status store.
// - Lock bit set with protect pin low rejects every status store.
// - Status byte: lock, three zeros, guard hi, guard lo, enable, busy.
// - Inputs sampled on rising clock edges, outputs change after falling edges.
// - Reset clears latch and busy, keeps stored bits, leaves device deselected.
// - The three unused status bits read zero and ignore status stores.
package sec_pkg;

  localparam int          BYTE_BITS   = 8;
  localparam int          ADDR_W      = 11;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BYTES_CTRL  = 3'h1;
  localparam logic [2:0]  BYTES_STORE = 3'h2;
  localparam logic [2:0]  BYTES_ADDR  = 3'h2;
  localparam logic [2:0]  BYTES_WRITE = 3'h3;
  localparam logic [2:0]  BYTES_SAT   = 3'h7;

  // Opcodes.
  localparam logic [7:0]  OP_SET_EN   = 8'h06;
  localparam logic [7:0]  OP_CLR_EN   = 8'h04;
  localparam logic [7:0]  OP_ST_READ  = 8'h05;
  localparam logic [7:0]  OP_ST_STORE = 8'h01;
  localparam logic [7:0]  OP_MEM_RD   = 8'h03;
  localparam logic [7:0]  OP_MEM_WR   = 8'h02;
  localparam logic [7:0]  OP_ID_RD    = 8'h83;
  localparam logic [7:0]  OP_ID_WR    = 8'h82;

  // Guarded region bases.
  localparam logic [10:0] GUARD_QUARTER = 11'h600;
  localparam logic [10:0] GUARD_HALF    = 11'h400;
  localparam logic [1:0]  GUARD_NONE_C  = 2'h0;
  localparam logic [1:0]  GUARD_QTR_C   = 2'h1;
  localparam logic [1:0]  GUARD_HALF_C  = 2'h2;

  // Status byte layout.
  localparam int          ST_LOCK_POS = 7;
  localparam int          ST_HI_POS   = 3;
  localparam int          ST_LO_POS   = 2;
  localparam logic [2:0]  ST_ZEROS    = 3'h0;
  localparam logic [2:0]  NV_RESET    = 3'h0;
  localparam int          WRITE_CYCLES_DEF = 64;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic prot_n;
  } sec_link_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    logic [BYTE_BITS-1:0] data;
  } sec_wr_word_t;

  typedef enum logic [6:0] {
    ST_OPC    = 7'h01,
    ST_ADDR   = 7'h02,
    ST_WDATA  = 7'h04,
    ST_SDATA  = 7'h08,
    ST_SOUT   = 7'h10,
    ST_RDATA  = 7'h20,
    ST_IGNORE = 7'h40
  } sec_state_t;

endpackage : sec_pkg

// >>> hw/sec_top.sv
// Small write buffer; flush drops everything queued.
module sec_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Full and empty come from the occupancy count.
  assign in_ready  = (count_reg != DEPTH_C);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  // Pointers wrap at the depth.
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg <= count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule : sec_fifo

// Serial EEPROM instruction decoder and protection logic.
module sec_top #(
  parameter int WRITE_CYCLES = sec_pkg::WRITE_CYCLES_DEF,
  parameter int FIFO_DEPTH   = 4,
  parameter bit HAS_IDPAGE   = 1'b1
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Serial link pins
  input  wire sec_pkg::sec_link_in_t link_in,
  output logic                       link_dout,
  output logic                       link_dout_oe,
  // Memory array write port
  output logic                       mem_wr_valid,
  input  wire logic                  mem_wr_ready,
  output sec_pkg::sec_wr_word_t      mem_wr_word,
  // Memory array read port
  output logic [10:0]                mem_rd_addr,
  input  wire logic [7:0]            mem_rd_data,
  // Status view
  output logic [7:0]                 status_out
);
  import sec_pkg::*;

  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam logic [CW-1:0] WRITE_LAST = CW'(WRITE_CYCLES - 1);

  logic [1:0]           rst_sync_reg;
  sec_link_in_t         sync1_reg, sync2_reg;
  logic                 sclk_q_reg, cs_q_reg, selected_reg;
  sec_state_t           state_reg;
  logic [7:0]           shift_reg, op_reg, out_shift_reg, sdata_reg;
  logic [2:0]           bit_cnt_reg, byte_cnt_reg, out_cnt_reg;
  logic [15:0]          addr_in_reg;
  logic [ADDR_W-1:0]    addr_cur_reg;
  logic                 reject_reg, enable_reg, busy_reg, job_store_reg;
  logic [2:0]           nv_reg = NV_RESET;
  logic [CW-1:0]        timer_reg;
  logic                 flush_reg;
  logic                 fifo_in_ready, fifo_out_valid;
  sec_wr_word_t         fifo_out_data;
  wire                  rst_n = rst_sync_reg[1];

  // Reset release is synchronised so that every flop on rst_n leaves reset together.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rst_sync_reg <= 2'h0;
    else       rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // Link pins come from the master's domain; edges are found after two flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, prot_n: 1'b1};
      sync2_reg  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, prot_n: 1'b1};
      sclk_q_reg <= 1'b0;
      cs_q_reg   <= 1'b1;
    end else begin
      sync1_reg  <= link_in;
      sync2_reg  <= sync1_reg;
      sclk_q_reg <= sync2_reg.sclk;
      cs_q_reg   <= sync2_reg.cs_n;
    end
  end

  // Edge events and decoded byte.
  wire        sclk_rise = sync2_reg.sclk & ~sclk_q_reg;
  wire        sclk_fall = ~sync2_reg.sclk & sclk_q_reg;
  wire        cs_rise   = sync2_reg.cs_n & ~cs_q_reg;
  wire        cs_fall   = ~sync2_reg.cs_n & cs_q_reg;
  wire        bit_in    = selected_reg & sclk_rise & ~cs_rise;
  wire        bit_out   = selected_reg & sclk_fall & ~cs_rise;
  wire        byte_done = bit_in & (bit_cnt_reg == BIT_LAST);
  wire [7:0]  byte_val  = {shift_reg[6:0], sync2_reg.din};
  wire [15:0] addr_full = {addr_in_reg[7:0], byte_val};
  wire        hard_lock = nv_reg[2] & ~sync2_reg.prot_n;
  wire [7:0]  status    = {nv_reg[2], ST_ZEROS, nv_reg[1:0], enable_reg, busy_reg};

  // Guarded-region test for one address.
  function automatic logic guard_hit(input logic [1:0] g, input logic [ADDR_W-1:0] a);
    case (g)
      GUARD_NONE_C: guard_hit = 1'b0;
      GUARD_QTR_C:  guard_hit = (a >= GUARD_QUARTER);
      GUARD_HALF_C: guard_hit = (a >= GUARD_HALF);
      default:      guard_hit = 1'b1;
    endcase
  endfunction : guard_hit

  // Opcode decode; writes are refused at once while a cycle is running.
  wire id_op = HAS_IDPAGE & ((byte_val == OP_ID_RD) | (byte_val == OP_ID_WR));
  wire known = (byte_val == OP_SET_EN) | (byte_val == OP_CLR_EN) |
               (byte_val == OP_ST_READ) | (byte_val == OP_ST_STORE) |
               (byte_val == OP_MEM_RD) | (byte_val == OP_MEM_WR) | id_op;
  sec_state_t opc_next;
  always_comb begin
    case (byte_val)
      OP_ST_READ:  opc_next = ST_SOUT;
      OP_ST_STORE: opc_next = busy_reg ? ST_IGNORE : ST_SDATA;
      OP_MEM_RD:   opc_next = busy_reg ? ST_IGNORE : ST_ADDR;
      OP_MEM_WR:   opc_next = busy_reg ? ST_IGNORE : ST_ADDR;
      default:     opc_next = id_op ? ST_ADDR : ST_IGNORE;
    endcase
  end

  // Next state after the second address byte.
  wire        addr_last  = (byte_cnt_reg == BYTES_ADDR);
  sec_state_t addr_next;
  assign addr_next = (op_reg == OP_MEM_WR) ? ST_WDATA :
                     (op_reg == OP_MEM_RD) ? ST_RDATA : ST_IGNORE;

  // Main decode state; a rising select always restarts at the opcode.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OPC;
    end else if (cs_rise || cs_fall) begin
      state_reg <= ST_OPC;
    end else if (byte_done) begin
      case (state_reg)
        ST_OPC:   state_reg <= known ? opc_next : ST_IGNORE;
        ST_ADDR:  state_reg <= addr_last ? addr_next : ST_ADDR;
        ST_SDATA: state_reg <= ST_IGNORE;
        default:  state_reg <= state_reg;
      endcase
    end
  end

  // Input shifting and counting; the counters restart on every select edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selected_reg <= 1'b0;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (cs_rise || cs_fall) begin
      selected_reg <= cs_fall;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (bit_in) begin
      shift_reg    <= byte_val;
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      if (byte_done && byte_cnt_reg != BYTES_SAT) byte_cnt_reg <= byte_cnt_reg + 3'h1;
    end
  end

  // Opcode, address and store data capture.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg      <= 8'h00;
      addr_in_reg <= 16'h0000;
      sdata_reg   <= 8'h00;
    end else if (byte_done) begin
      if (state_reg == ST_OPC) op_reg <= known ? byte_val : 8'h00;
      if (state_reg == ST_ADDR) addr_in_reg <= addr_full;
      if (state_reg == ST_SDATA) sdata_reg <= byte_val;
    end
  end

  // Each written byte is guard-checked and queued; overflow discards the command.
  wire wr_byte  = byte_done & (state_reg == ST_WDATA);
  wire wr_guard = guard_hit(nv_reg[1:0], addr_cur_reg);
  wire wr_push  = wr_byte & ~reject_reg & ~wr_guard & fifo_in_ready;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reject_reg <= 1'b0;
    end else if (cs_fall) begin
      reject_reg <= 1'b0;
    end else if (wr_byte && (wr_guard || !fifo_in_ready)) begin
      reject_reg <= 1'b1;
    end
  end

  // Address counter; the five top address bits are ignored and reads roll over.
  wire rd_load = bit_out & (state_reg == ST_RDATA) & (out_cnt_reg == 3'h0);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cur_reg <= '0;
    end else if (byte_done && state_reg == ST_ADDR && addr_last) begin
      addr_cur_reg <= addr_full[ADDR_W-1:0];
    end else if (wr_byte || rd_load) begin
      addr_cur_reg <= addr_cur_reg + ADDR_W'(1);
    end
  end

  // Output shifting after falling edges; status repeats while clocks continue.
  wire       out_state = (state_reg == ST_SOUT) | (state_reg == ST_RDATA);
  wire [7:0] out_src   = (state_reg == ST_SOUT) ? status : mem_rd_data;
  wire [7:0] out_word  = (out_cnt_reg == 3'h0) ? out_src : out_shift_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift_reg <= 8'h00;
      out_cnt_reg   <= 3'h0;
      link_dout     <= 1'b0;
      link_dout_oe  <= 1'b0;
    end else begin
      link_dout_oe <= selected_reg & ~cs_rise & out_state;
      if (cs_rise || cs_fall) begin
        out_cnt_reg <= 3'h0;
      end else if (bit_out && out_state) begin
        link_dout     <= out_word[7];
        out_shift_reg <= {out_word[6:0], 1'b0};
        out_cnt_reg   <= out_cnt_reg + 3'h1;
      end
    end
  end

  // Termination checks at deselect: whole bytes and the right byte count.
  wire whole     = (bit_cnt_reg == 3'h0);
  wire go_set    = (op_reg == OP_SET_EN) & whole & (byte_cnt_reg == BYTES_CTRL);
  wire go_clr    = (op_reg == OP_CLR_EN) & whole & (byte_cnt_reg == BYTES_CTRL);
  wire go_write  = (op_reg == OP_MEM_WR) & whole & (byte_cnt_reg >= BYTES_WRITE) &
                   enable_reg & ~reject_reg & ~busy_reg & fifo_out_valid;
  wire go_store  = (op_reg == OP_ST_STORE) & whole & (byte_cnt_reg == BYTES_STORE) &
                   enable_reg & ~hard_lock & ~busy_reg;
  wire commit    = cs_rise & (go_write | go_store);
  wire drain_rdy = busy_reg & (~mem_wr_valid | mem_wr_ready);
  wire drained   = busy_reg & ~fifo_out_valid & ~mem_wr_valid;
  wire cycle_end = drained & (timer_reg == WRITE_LAST);

  // Anything queued by a discarded command is dropped at deselect.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flush_reg <= 1'b0;
    else        flush_reg <= cs_rise & ~busy_reg & ~go_write;
  end

  // Enable latch, busy flag and the self-timed cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg    <= 1'b0;
      busy_reg      <= 1'b0;
      job_store_reg <= 1'b0;
      timer_reg     <= '0;
    end else begin
      if (cycle_end) enable_reg <= 1'b0;
      else if (cs_rise && go_clr) enable_reg <= 1'b0;
      else if (cs_rise && go_set) enable_reg <= 1'b1;
      if (commit) begin
        busy_reg      <= 1'b1;
        job_store_reg <= go_store;
        timer_reg     <= '0;
      end else if (cycle_end) begin
        busy_reg      <= 1'b0;
      end else if (drained) begin
        timer_reg     <= timer_reg + CW'(1);
      end
    end
  end

  // Stored bits change only when a status store cycle finishes. They are non-volatile,
  // so a reset leaves them alone; they start from the delivery value instead.
  always_ff @(posedge core_clk) begin
    if (cycle_end && job_store_reg) begin
      nv_reg <= {sdata_reg[ST_LOCK_POS], sdata_reg[ST_HI_POS], sdata_reg[ST_LO_POS]};
    end
  end

  // Write port register toward the array, fed only after a commit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_valid <= 1'b0;
      mem_wr_word  <= '0;
    end else if (drain_rdy) begin
      mem_wr_valid <= fifo_out_valid;
      mem_wr_word  <= fifo_out_data;
    end
  end

  // Read address and status view.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_addr <= '0;
      status_out  <= 8'h00;
    end else begin
      mem_rd_addr <= addr_cur_reg;
      status_out  <= status;
    end
  end

  sec_fifo #(
    .WIDTH ($bits(sec_wr_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .flush     (flush_reg),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr_cur_reg, byte_val}),
    .out_valid (fifo_out_valid),
    .out_ready (drain_rdy),
    .out_data  (fifo_out_data)
  );
endmodule : sec_top

// >>> sim/sec_top_props.sv
module sec_top_props (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rstn,
  // Link pins
  input wire sec_pkg::sec_link_in_t link_in,
  input wire logic                  link_dout,
  input wire logic                  link_dout_oe,
  // Array ports and status
  input wire logic                  mem_wr_valid,
  input wire logic                  mem_wr_ready,
  input wire sec_pkg::sec_wr_word_t mem_wr_word,
  input wire logic [10:0]           mem_rd_addr,
  input wire logic [7:0]            mem_rd_data,
  input wire logic [7:0]            status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // A word is guarded when its address lies inside the region picked by the guard bits.
  wire logic [1:0] gbits   = status_out[3:2];
  wire logic       guarded = (gbits == 2'h3) ||
                             (gbits == 2'h2 && mem_wr_word.addr >= GUARD_HALF) ||
                             (gbits == 2'h1 && mem_wr_word.addr >= GUARD_QUARTER);

  // Deselected long enough for the synchroniser to have seen it.
  sequence s_desel;
    link_in.cs_n [*6];
  endsequence
  sequence s_busy_end;
    $fell(status_out[0]);
  endsequence

  property p_zero_bits;
    status_out[6:4] == 3'h0;
  endproperty
  property p_set_at_desel;
    $rose(status_out[1]) |-> link_in.cs_n;
  endproperty
  property p_busy_needs_en;
    $rose(status_out[0]) |-> status_out[1];
  endproperty
  property p_end_clears;
    s_busy_end |-> ##[0:1] !status_out[1];
  endproperty
  property p_drain_first;
    s_busy_end |-> !mem_wr_valid && $past(!mem_wr_valid, 2);
  endproperty
  property p_guard;
    mem_wr_valid |-> !guarded;
  endproperty
  property p_oe_desel;
    s_desel |-> !link_dout_oe;
  endproperty
  property p_dout_fall;
    link_dout_oe && $changed(link_dout) |-> !link_in.sclk;
  endproperty

  a_zero_bits:     assert property (p_zero_bits) else $error("unused status bits set");
  a_set_at_desel:  assert property (p_set_at_desel) else $error("enable set while selected");
  a_busy_needs_en: assert property (p_busy_needs_en) else $error("busy without enable");
  a_end_clears:    assert property (p_end_clears) else $error("enable kept after cycle");
  a_drain_first:   assert property (p_drain_first) else $error("busy ended early");
  a_guard:         assert property (p_guard) else $error("guarded word written");
  a_oe_desel:      assert property (p_oe_desel) else $error("driving while deselected");
  a_dout_fall:     assert property (p_dout_fall) else $error("output moved off fall");
endmodule : sec_top_props

bind sec_top sec_top_props u_props (
  .core_clk     (core_clk),
  .rstn         (rstn),
  .link_in      (link_in),
  .link_dout    (link_dout),
  .link_dout_oe (link_dout_oe),
  .mem_wr_valid (mem_wr_valid),
  .mem_wr_ready (mem_wr_ready),
  .mem_wr_word  (mem_wr_word),
  .mem_rd_addr  (mem_rd_addr),
  .mem_rd_data  (mem_rd_data),
  .status_out   (status_out)
);

// >>> sim/sec_spi_master.sv
module sec_spi_master (
  // Clock
  input wire logic            core_clk,
  // Link pins
  output sec_pkg::sec_link_in_t link_in,
  input wire logic            link_dout,
  input wire logic            link_dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  localparam int HALF = 10;
  logic cpol   = 1'b0;
  logic last_q = 1'b0;
  // No pull on the data line, so a released line shows the inverse of its last value.
  wire logic line_q = link_dout_oe ? link_dout : ~last_q;
  initial link_in = '{1'b1, 1'b0, 1'b0, 1'b1};
  always @(posedge core_clk) if (link_dout_oe) last_q <= link_dout;

  task automatic half();
    repeat (HALF) @(posedge core_clk);
  endtask : half
  task automatic set_mode(input logic md);
    link_in.sclk <= md;
    cpol = md;
    half();
  endtask : set_mode
  task automatic set_prot(input logic p);
    link_in.prot_n <= p;
    half();
  endtask : set_prot
  task automatic sel();
    half();
    link_in.cs_n <= 1'b0;
    half();
  endtask : sel
  // Deselect right after the last rising edge, before any further one.
  task automatic desel();
    link_in.cs_n <= 1'b1;
    half();
    half();
  endtask : desel
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (cpol) link_in.sclk <= 1'b0;
      link_in.din <= tx[i];
      half();
      rx[i] = line_q;
      link_in.sclk <= 1'b1;
      half();
      if (!cpol) link_in.sclk <= 1'b0;
    end
  endtask : xbits
endmodule : sec_spi_master

// >>> sim/tb_sec_top.sv
module tb_sec_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sec_pkg::*;
  typedef struct {logic [1:0] g; logic [15:0] a; int n;} sec_row_t;
  sec_row_t rows [8] = '{'{2'h0, 16'hf7ff, 1}, '{2'h1, 16'h05ff, 1}, '{2'h1, 16'h0600, 0},
    '{2'h2, 16'h03ff, 1}, '{2'h2, 16'h0400, 0}, '{2'h3, 16'h0000, 0},
    '{2'h3, 16'h07ff, 0}, '{2'h0, 16'h0000, 1}};
  logic         core_clk     = 1'b0;
  logic         rstn         = 1'b0;
  logic         mem_wr_ready = 1'b0;
  logic [7:0]   mem_rd_data  = 8'h00;
  sec_link_in_t link_in;
  logic         link_dout;
  logic         link_dout_oe;
  logic         mem_wr_valid;
  sec_wr_word_t mem_wr_word;
  logic [10:0]  mem_rd_addr;
  logic [7:0]   status_out;
  logic [7:0]   rx;
  logic [7:0]   st;
  logic [7:0]   first_st;
  sec_wr_word_t seen [$];
  int           error_cnt  = 0;
  int           num_checks = 0;
  int           k;

  initial forever #2 core_clk = ~core_clk;

  sec_top #(.WRITE_CYCLES(400)) dut (
    .core_clk(core_clk), .rstn(rstn), .link_in(link_in), .link_dout(link_dout),
    .link_dout_oe(link_dout_oe), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_word(mem_wr_word), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .status_out(status_out));
  sec_spi_master m (.core_clk(core_clk), .link_in(link_in), .link_dout(link_dout),
    .link_dout_oe(link_dout_oe));

  // Array stand-in stalls every other cycle so the write buffer has to hold words.
  always @(posedge core_clk) begin
    mem_wr_ready <= ~mem_wr_ready;
    mem_rd_data  <= ~mem_rd_addr[7:0];
    if (mem_wr_valid && mem_wr_ready) seen.push_back(mem_wr_word);
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [18:0] sv, input logic [18:0] ev);
    num_checks++;
    if (sv !== ev) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, ev, sv);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op, input int n);
    m.sel();
    m.xbits(op, n, rx);
    m.desel();
  endtask : cmd
  task automatic status_read_cmd(output logic [7:0] s);
    logic [7:0] s2;
    m.sel();
    m.xbits(OP_ST_READ, 8, rx);
    m.xbits(8'h00, 8, s);
    m.xbits(8'h00, 8, s2);
    m.desel();
    // A write cycle may end between the two copies; busy and enable then drop together.
    check("status repeat", 19'(s2), 19'((s[0] && !s2[0]) ? {s[7:2], 2'b00} : s));
  endtask : status_read_cmd
  // Polling the busy flag over the link keeps the host side honest about the write cycle.
  task automatic wait_idle();
    for (k = 0; k < 20; k++) begin
      status_read_cmd(st);
      if (k == 0) first_st = st;
      if (st[0] === 1'b0) break;
    end
    if (k == 20) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_idle
  task automatic status_store_cmd(input logic [7:0] v);
    cmd(OP_SET_EN, 8);
    m.sel();
    m.xbits(OP_ST_STORE, 8, rx);
    m.xbits(v, 8, rx);
    m.desel();
    wait_idle();
  endtask : status_store_cmd
  task automatic wr(input logic en, input logic [15:0] a, input int n, input int nb);
    if (en) cmd(OP_SET_EN, 8);
    seen.delete();
    m.sel();
    m.xbits(OP_MEM_WR, 8, rx);
    m.xbits(a[15:8], 8, rx);
    m.xbits(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) m.xbits(8'ha0 + 8'(i), (i == n - 1) ? nb : 8, rx);
    m.desel();
    wait_idle();
  endtask : wr
  task automatic chk_wr(input logic [10:0] a, input int n);
    check("word count", 19'(seen.size()), 19'(n));
    for (int i = 0; i < n && i < seen.size(); i++) begin
      check("word", seen[i], {a + 11'(i), 8'ha0 + 8'(i)});
    end
  endtask : chk_wr

  // Table of guard settings against target addresses, then the awkward cases by hand.
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("reset status", 19'(status_out), 19'h0);
    check("reset oe", 19'(link_dout_oe), 19'h0);
    foreach (rows[r]) begin
      status_store_cmd({4'h0, rows[r].g, 2'h0});
      check("stored status", 19'(st), 19'({4'h0, rows[r].g, 2'h0}));
      wr(1'b1, rows[r].a, 1, 8);
      chk_wr(rows[r].a[10:0], rows[r].n);
    end
    wr(1'b0, 16'h0010, 1, 8);
    chk_wr(11'h010, 0);
    wr(1'b1, 16'h0010, 1, 7);
    chk_wr(11'h010, 0);
    cmd(OP_SET_EN, 8);
    status_read_cmd(st);
    check("enable set", 19'(st[1]), 19'h1);
    cmd(OP_CLR_EN, 8);
    status_read_cmd(st);
    check("enable cleared", 19'(st[1]), 19'h0);
    cmd(OP_SET_EN, 7);
    status_read_cmd(st);
    check("short enable", 19'(st[1]), 19'h0);
    m.sel();
    m.xbits(8'hff, 8, rx);
    m.xbits(OP_SET_EN, 8, rx);
    m.desel();
    status_read_cmd(st);
    check("unknown opcode", 19'(st[1]), 19'h0);
    // The identification opcode must not fall through to an array write.
    cmd(OP_SET_EN, 8);
    seen.delete();
    m.sel();
    m.xbits(OP_ID_WR, 8, rx);
    m.xbits(8'h04, 8, rx);
    m.xbits(8'h00, 8, rx);
    m.xbits(8'h5a, 8, rx);
    m.desel();
    status_read_cmd(st);
    check("id page ignored", 19'({st[1:0], 8'(seen.size())}), 19'h200);
    wr(1'b1, 16'h0100, 4, 8);
    chk_wr(11'h100, 4);
    check("busy seen", 19'(first_st[1:0]), 19'h3);
    check("enable after write", 19'(st[1]), 19'h0);
    wr(1'b1, 16'h0100, 5, 8);
    chk_wr(11'h100, 0);
    m.set_prot(1'b0);
    status_store_cmd(8'h80);
    status_store_cmd(8'h0c);
    // A refused store leaves the enable latch set.
    check("hard lock", 19'(st), 19'h82);
    m.set_prot(1'b1);
    status_store_cmd(8'h8c);
    check("lock lifted", 19'(st), 19'h8c);
    status_store_cmd(8'h00);
    m.sel();
    m.xbits(OP_MEM_RD, 8, rx);
    m.xbits(8'hff, 8, rx);
    m.xbits(8'hff, 8, rx);
    m.xbits(8'h00, 8, rx);
    check("read top", 19'(rx), 19'h00);
    m.xbits(8'h00, 8, rx);
    check("read wrap", 19'(rx), 19'hff);
    m.desel();
    m.set_mode(1'b1);
    cmd(OP_SET_EN, 8);
    status_read_cmd(st);
    check("idle high enable", 19'(st[1]), 19'h1);
    m.set_mode(1'b0);
    status_store_cmd(8'h04);
    cmd(OP_SET_EN, 8);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge core_clk);
    check("second reset", 19'(status_out), 19'h04);
    final_report();
  end
endmodule : tb_sec_top
